// ==== qsfi_pkg.sv ====
// constants, types and decode helpers of the quad serial flash front end
// Behaviour
// - capture command, address and input bits on rising serial clock edges.
// - change output data on falling serial clock edges.
// - enter-quad command turns the four data lines into a 4-bit two-way bus.
// - after reset use single-bit link: input line 0, output line 1.
// - selection and command start only on a falling chip-enable edge.
// - single-bit mode supports read, high-speed read and identification read.
// - array holds 4 KByte sectors, eight 8 KByte and two 32 KByte blocks.
// - four 8 KByte and one 32 KByte block sit at each end.
// - 30 or 62 uniform 64 KByte blocks, by density.
// - read bursts may wrap in aligned 8, 16, 32 or 64 byte windows.
// - index jumps within the page, within the block, or to another block.
// - program or erase may be suspended to reach another block.
// - 256 bit security identifier: 64 bit factory part, 192 bit user part.
// - write lock granularity is one lock per block of each size.
// - clock idle low or high between transfers, same sampling edges.
// - after reset only read, fast read, identification and enter-quad accepted.
package qsfi_pkg;

    // ==========================================================
    // command codes
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_HSREAD   = 8'h0B;
    localparam logic [7:0] OP_JEDEC    = 8'h9F;
    localparam logic [7:0] OP_QUAD_ON  = 8'h38;
    localparam logic [7:0] OP_RSTQ     = 8'hFF;
    localparam logic [7:0] OP_RDSR     = 8'h05;
    localparam logic [7:0] OP_BURST    = 8'hC0;
    localparam logic [7:0] OP_RDWRAP   = 8'h0C;
    localparam logic [7:0] OP_JMP_PAGE = 8'h8C;
    localparam logic [7:0] OP_JMP_BLK  = 8'h8D;
    localparam logic [7:0] OP_JMP_ANY  = 8'h8E;
    localparam logic [7:0] OP_RDSECID  = 8'h88;
    localparam logic [7:0] OP_PP       = 8'h02;
    localparam logic [7:0] OP_SE       = 8'h20;
    localparam logic [7:0] OP_BE       = 8'hD8;
    localparam logic [7:0] OP_CE       = 8'hC7;
    localparam logic [7:0] OP_WREN     = 8'h06;
    localparam logic [7:0] OP_WRDI     = 8'h04;
    localparam logic [7:0] OP_SUSP     = 8'hB0;
    localparam logic [7:0] OP_RESUME   = 8'h30;

    // ==========================================================
    // organisation and sizes
    localparam int SECTOR_SHIFT   = 12;
    localparam int PARAM_BYTES    = 8192;
    localparam int N_PARAM_END    = 4;
    localparam int HALF_BYTES     = 32768;
    localparam int BLOCK_BYTES    = 65536;
    localparam int N_BLK64_DEF    = 30;
    localparam int SECID_BYTES    = 32;
    localparam int SECID_UNIQ     = 8;
    localparam int WRAP_MIN_BYTES = 8;
    localparam int JEDEC_BYTES    = 3;
    localparam logic [1:0] BURST_RST = 2'b00;
    localparam logic       QUAD_RST  = 1'b0;
    localparam logic [3:0] OE_SPI    = 4'b0010;
    localparam logic [3:0] OE_QUAD   = 4'b1111;
    // arbitrary identification bytes
    localparam logic [23:0] ID_DEF   = 24'h5A_1234;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        K_NONE   = 4'b0000, K_READ  = 4'b0001, K_WRAP  = 4'b0010,
        K_HSREAD = 4'b0011, K_JEDEC = 4'b0100, K_STAT  = 4'b0101,
        K_WRITE  = 4'b0110, K_QUAD_ON = 4'b0111, K_RSTQ  = 4'b1000,
        K_JUMP   = 4'b1001, K_BURST = 4'b1010, K_SECID = 4'b1011
    } qsfi_kind_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_CMD = 3'b001, S_ADDR = 3'b010, S_DUMMY = 3'b011,
        S_OUT  = 3'b100, S_WIN = 3'b101, S_DROP = 3'b110
    } qsfi_state_t;

    typedef struct packed {
        logic       ok;
        logic [1:0] nadr;
        qsfi_kind_t kind;
    } qsfi_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [11:0] sector;
        logic [6:0]  lock_idx;
    } qsfi_evt_t;

    // ==========================================================
    // command decode, single-bit mode accepts only the legacy set
    function automatic qsfi_cmd_t cmd_decode(input logic [7:0] op, input logic quad);
        qsfi_cmd_t c;
        c = '{1'b1, 2'd0, K_NONE};
        case (op)
            OP_READ:     c = '{1'b1, 2'd3, K_READ};
            OP_HSREAD:   c = '{1'b1, 2'd3, K_HSREAD};
            OP_JEDEC:    c = '{1'b1, 2'd0, K_JEDEC};
            OP_QUAD_ON:  c = '{1'b1, 2'd0, K_QUAD_ON};
            OP_RSTQ:     c = '{1'b1, 2'd0, K_RSTQ};
            OP_RDSR:     c = '{1'b1, 2'd0, K_STAT};
            OP_BURST:    c = '{1'b1, 2'd0, K_BURST};
            OP_RDWRAP:   c = '{1'b1, 2'd3, K_WRAP};
            OP_JMP_PAGE: c = '{1'b1, 2'd1, K_JUMP};
            OP_JMP_BLK:  c = '{1'b1, 2'd2, K_JUMP};
            OP_JMP_ANY:  c = '{1'b1, 2'd3, K_JUMP};
            OP_RDSECID:  c = '{1'b1, 2'd2, K_SECID};
            OP_PP:       c = '{1'b1, 2'd3, K_WRITE};
            OP_SE:       c = '{1'b1, 2'd3, K_NONE};
            OP_BE:       c = '{1'b1, 2'd3, K_NONE};
            OP_CE, OP_WREN, OP_WRDI, OP_SUSP, OP_RESUME: c = '{1'b1, 2'd0, K_NONE};
            default:     c.ok = 1'b0;
        endcase
        if (!quad && !(op == OP_READ || op == OP_HSREAD || op == OP_JEDEC || op == OP_QUAD_ON))
        begin
            c.ok = 1'b0;
        end
        return c;
    endfunction

    // lock slot: 0-3 bottom 8K, 4-7 top 8K, 8/9 32K ends, 10+ 64K blocks
    function automatic logic [6:0] lock_index(input logic [23:0] a, input logic [6:0] nblk);
        logic [24:0] top;
        logic [24:0] rel;
        top = 25'({nblk, 16'h0000}) + 25'(2 * BLOCK_BYTES);
        rel = top - 25'(a) - 25'h1;
        if (25'(a) < 25'(N_PARAM_END * PARAM_BYTES))
            return {5'h00, a[14:13]};
        else if (25'(a) < 25'(BLOCK_BYTES))
            return 7'h08;
        else if (rel < 25'(HALF_BYTES))
            return 7'h04 + {5'h00, a[14:13]};
        else if (rel < 25'(BLOCK_BYTES))
            return 7'h09;
        else
            return 7'(a[23:16]) + 7'h09;
    endfunction

    // next read address, wrapping inside an aligned window of mask+1 bytes
    function automatic logic [23:0] next_addr(input logic [23:0] p, input logic [23:0] mask);
        logic [23:0] inc;
        inc = p + 24'h1;
        return (p & ~mask) | (inc & mask);
    endfunction

endpackage

// ==== qsfi_core.sv ====
// serial command front end of a quad-capable flash device
`timescale 1ns/1ns
`default_nettype none
module qsfi_core #(
    parameter logic [6:0]  N_BLK64 = 7'(qsfi_pkg::N_BLK64_DEF),
    parameter logic [23:0] ID      = qsfi_pkg::ID_DEF
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // link pins
    input  wire logic             i_ce_n,
    input  wire logic             i_sck,
    input  wire logic [3:0]       i_quad_data_lines,
    output logic      [3:0]       o_quad_data_lines,
    output logic      [3:0]       o_quad_data_lines_oe,
    // array side
    output logic      [23:0]      o_rd_addr,
    output logic                  o_rd_secid,
    input  wire logic [7:0]       i_rd_data,
    input  wire logic [7:0]       i_status,
    output qsfi_pkg::qsfi_evt_t   o_evt,
    output logic      [7:0]       o_wdata,
    output logic                  o_wvalid,
    output logic                  o_quad,
    output logic      [1:0]       o_burst
);

    // ==========================================================
    // pin synchronisers and edge detect
    logic [2:0] sck_sy_ff;
    logic [2:0] ce_sy_ff;
    logic [3:0] d_s1_ff;
    logic [3:0] d_s2_ff;
    logic       sck_rise;
    logic       sck_fall;
    logic       ce_s;
    logic       ce_fall;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sck_sy_ff <= 3'h0;
            ce_sy_ff  <= 3'h7;
            d_s1_ff   <= 4'h0;
            d_s2_ff   <= 4'h0;
        end
        else
        begin
            sck_sy_ff <= {sck_sy_ff[1:0], i_sck};
            ce_sy_ff  <= {ce_sy_ff[1:0], i_ce_n};
            d_s1_ff   <= i_quad_data_lines;
            d_s2_ff   <= d_s1_ff;
        end
    end

    // either idle level works: only edges inside a selection act
    assign sck_rise = sck_sy_ff[1] & ~sck_sy_ff[2];
    assign sck_fall = ~sck_sy_ff[1] & sck_sy_ff[2];
    assign ce_s     = ce_sy_ff[1];
    assign ce_fall  = ~ce_sy_ff[1] & ce_sy_ff[2];

    // ==========================================================
    // command engine
    qsfi_pkg::qsfi_state_t state_ff, nxt_state;
    qsfi_pkg::qsfi_kind_t  kind_ff, nxt_kind;
    qsfi_pkg::qsfi_evt_t   evt_ff, nxt_evt;
    qsfi_pkg::qsfi_cmd_t   c_dec;
    qsfi_pkg::qsfi_kind_t  f_kind;
    logic        quad_ff, nxt_quad;
    logic [7:0]  op_ff, nxt_op;
    logic [1:0]  nadr_ff, nxt_nadr;
    logic [2:0]  cnt_ff, nxt_cnt;
    logic [7:0]  sh_ff, nxt_sh;
    logic [23:0] addr_ff, nxt_addr;
    logic [23:0] ptr_ff, nxt_ptr;
    logic [1:0]  burst_ff, nxt_burst;
    logic [7:0]  tx_ff, nxt_tx;
    logic [3:0]  dout_ff, nxt_dout;
    logic [3:0]  oe_ff, nxt_oe;
    logic [1:0]  jidx_ff, nxt_jidx;
    logic        secid_ff, nxt_secid;
    logic [7:0]  wdata_ff, nxt_wdata;
    logic        wvalid_ff, nxt_wvalid;
    logic [7:0]  sh_n;
    logic [2:0]  cnt_n;
    logic        byte_done;
    logic        fin;
    logic [23:0] f_addr;
    logic [23:0] wmask;
    logic [7:0]  src;
    logic [7:0]  obyte;
    logic [7:0]  oshift;

    assign sh_n      = quad_ff ? {sh_ff[3:0], d_s2_ff} : {sh_ff[6:0], d_s2_ff[0]};
    assign cnt_n     = cnt_ff + (quad_ff ? 3'd4 : 3'd1);
    assign byte_done = (cnt_n == 3'd0);
    assign wmask     = (kind_ff == qsfi_pkg::K_SECID) ? 24'(qsfi_pkg::SECID_BYTES - 1)
                     : (kind_ff == qsfi_pkg::K_WRAP)
                     ? ((24'(qsfi_pkg::WRAP_MIN_BYTES) << burst_ff) - 24'h1)
                     : 24'hFF_FFFF;
    assign src       = (kind_ff == qsfi_pkg::K_JEDEC) ? ID[8'(23 - 8 * jidx_ff) -: 8]
                     : (kind_ff == qsfi_pkg::K_STAT) ? i_status : i_rd_data;
    assign obyte     = (cnt_ff == 3'd0) ? src : tx_ff;
    assign oshift    = obyte << cnt_ff;

    always_comb
    begin
        nxt_state = state_ff;   nxt_kind  = kind_ff;   nxt_quad   = quad_ff;
        nxt_op    = op_ff;      nxt_nadr  = nadr_ff;   nxt_cnt    = cnt_ff;
        nxt_sh    = sh_ff;      nxt_addr  = addr_ff;   nxt_ptr    = ptr_ff;
        nxt_burst = burst_ff;   nxt_tx    = tx_ff;     nxt_dout   = dout_ff;
        nxt_oe    = oe_ff;      nxt_jidx  = jidx_ff;   nxt_secid  = secid_ff;
        nxt_wdata = wdata_ff;   nxt_wvalid = 1'b0;
        nxt_evt   = evt_ff;
        nxt_evt.valid = 1'b0;
        c_dec  = qsfi_pkg::cmd_decode(sh_n, quad_ff);
        fin    = 1'b0;
        f_kind = kind_ff;
        f_addr = {addr_ff[15:0], sh_n};
        if (ce_s)
        begin
            nxt_state = qsfi_pkg::S_IDLE;
            nxt_oe    = 4'h0;
        end
        else if (ce_fall)
        begin
            nxt_state = qsfi_pkg::S_CMD;
            nxt_cnt   = 3'd0;
            nxt_oe    = 4'h0;
        end
        else if (sck_rise && (state_ff == qsfi_pkg::S_CMD || state_ff == qsfi_pkg::S_ADDR
                 || state_ff == qsfi_pkg::S_DUMMY || state_ff == qsfi_pkg::S_WIN))
        begin
            nxt_sh  = sh_n;
            nxt_cnt = cnt_n;
            if (byte_done)
            begin
                case (state_ff)
                    qsfi_pkg::S_CMD:
                    begin
                        nxt_op   = sh_n;
                        nxt_kind = c_dec.kind;
                        nxt_nadr = c_dec.nadr;
                        f_kind   = c_dec.kind;
                        if (!c_dec.ok)
                            nxt_state = qsfi_pkg::S_DROP;
                        else if (c_dec.nadr != 2'd0)
                            nxt_state = qsfi_pkg::S_ADDR;
                        else
                            fin = 1'b1;
                    end
                    qsfi_pkg::S_ADDR:
                    begin
                        nxt_addr = f_addr;
                        nxt_nadr = nadr_ff - 2'd1;
                        fin      = (nadr_ff == 2'd1);
                    end
                    qsfi_pkg::S_DUMMY: nxt_state = qsfi_pkg::S_OUT;
                    qsfi_pkg::S_WIN:
                    begin
                        if (kind_ff == qsfi_pkg::K_BURST)
                        begin
                            nxt_burst = sh_n[1:0];
                            nxt_state = qsfi_pkg::S_DROP;
                        end
                        else
                        begin
                            nxt_wdata  = sh_n;
                            nxt_wvalid = 1'b1;
                        end
                    end
                    default: nxt_state = qsfi_pkg::S_DROP;
                endcase
            end
        end
        else if (sck_fall && state_ff == qsfi_pkg::S_OUT)
        begin
            nxt_tx   = obyte;
            nxt_dout = quad_ff ? oshift[7:4] : {2'b00, oshift[7], 1'b0};
            nxt_oe   = quad_ff ? qsfi_pkg::OE_QUAD : qsfi_pkg::OE_SPI;
            nxt_cnt  = cnt_n;
            if (byte_done)
            begin
                nxt_ptr  = qsfi_pkg::next_addr(ptr_ff, wmask);
                nxt_jidx = (jidx_ff == 2'(qsfi_pkg::JEDEC_BYTES - 1)) ? 2'd0 : jidx_ff + 2'd1;
            end
        end
        if (fin)
        begin
            nxt_secid = 1'b0;
            nxt_state = qsfi_pkg::S_DROP;
            case (f_kind)
                qsfi_pkg::K_READ, qsfi_pkg::K_WRAP:
                begin
                    nxt_ptr   = f_addr;
                    nxt_state = qsfi_pkg::S_OUT;
                end
                qsfi_pkg::K_HSREAD:
                begin
                    nxt_ptr   = f_addr;
                    nxt_state = qsfi_pkg::S_DUMMY;
                end
                qsfi_pkg::K_SECID:
                begin
                    nxt_ptr   = f_addr & 24'(qsfi_pkg::SECID_BYTES - 1);
                    nxt_secid = 1'b1;
                    nxt_state = qsfi_pkg::S_OUT;
                end
                qsfi_pkg::K_JUMP:
                begin
                    nxt_state = qsfi_pkg::S_OUT;
                    case (op_ff)
                        qsfi_pkg::OP_JMP_PAGE: nxt_ptr = {ptr_ff[23:8], f_addr[7:0]};
                        qsfi_pkg::OP_JMP_BLK:  nxt_ptr = {ptr_ff[23:16], f_addr[15:0]};
                        default:               nxt_ptr = f_addr;
                    endcase
                end
                qsfi_pkg::K_JEDEC:
                begin
                    nxt_jidx  = 2'd0;
                    nxt_state = qsfi_pkg::S_OUT;
                end
                qsfi_pkg::K_STAT: nxt_state = qsfi_pkg::S_OUT;
                qsfi_pkg::K_QUAD_ON: nxt_quad = 1'b1;
                qsfi_pkg::K_RSTQ: nxt_quad = 1'b0;
                qsfi_pkg::K_BURST: nxt_state = qsfi_pkg::S_WIN;
                default:
                begin
                    // program, erase, suspend, resume and latch commands
                    nxt_evt.valid    = 1'b1;
                    nxt_evt.op       = (state_ff == qsfi_pkg::S_CMD) ? sh_n : op_ff;
                    nxt_evt.addr     = f_addr;
                    nxt_evt.sector   = f_addr[23:qsfi_pkg::SECTOR_SHIFT];
                    nxt_evt.lock_idx = qsfi_pkg::lock_index(f_addr, N_BLK64);
                    if (f_kind == qsfi_pkg::K_WRITE)
                        nxt_state = qsfi_pkg::S_WIN;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff <= qsfi_pkg::S_IDLE;  kind_ff  <= qsfi_pkg::K_NONE;
            quad_ff  <= qsfi_pkg::QUAD_RST;  op_ff    <= 8'h00;
            nadr_ff  <= 2'd0;  cnt_ff   <= 3'd0;  sh_ff    <= 8'h00;
            addr_ff  <= 24'h00_0000;  ptr_ff   <= 24'h00_0000;
            burst_ff <= qsfi_pkg::BURST_RST;  tx_ff    <= 8'h00;
            dout_ff  <= 4'h0;  oe_ff    <= 4'h0;  jidx_ff  <= 2'd0;
            secid_ff <= 1'b0;  wdata_ff <= 8'h00;  wvalid_ff <= 1'b0;
            evt_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;  kind_ff  <= nxt_kind;   quad_ff   <= nxt_quad;
            op_ff    <= nxt_op;     nadr_ff  <= nxt_nadr;   cnt_ff    <= nxt_cnt;
            sh_ff    <= nxt_sh;     addr_ff  <= nxt_addr;   ptr_ff    <= nxt_ptr;
            burst_ff <= nxt_burst;  tx_ff    <= nxt_tx;     dout_ff   <= nxt_dout;
            oe_ff    <= nxt_oe;     jidx_ff  <= nxt_jidx;   secid_ff  <= nxt_secid;
            wdata_ff <= nxt_wdata;  wvalid_ff <= nxt_wvalid; evt_ff   <= nxt_evt;
        end
    end

    assign o_quad_data_lines    = dout_ff;
    assign o_quad_data_lines_oe = oe_ff;
    assign o_rd_addr            = ptr_ff;
    assign o_rd_secid           = secid_ff;
    assign o_evt                = evt_ff;
    assign o_wdata              = wdata_ff;
    assign o_wvalid             = wvalid_ff;
    assign o_quad               = quad_ff;
    assign o_burst              = burst_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_sel_start;
        (state_ff == qsfi_pkg::S_IDLE) ##1 (state_ff != qsfi_pkg::S_IDLE);
    endsequence
    sequence s_bad_legacy;
        state_ff == qsfi_pkg::S_CMD && sck_rise && byte_done && !quad_ff && !c_dec.ok && !ce_s;
    endsequence

    property p_in_rise;
        $changed(sh_ff) |-> $past(sck_rise);
    endproperty
    a_in_rise: assert property (p_in_rise) else $error("shift changed off rising edge");
    property p_out_fall;
        $changed(dout_ff) |-> $past(sck_fall);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("output changed off falling edge");
    property p_quad_oe;
        quad_ff && oe_ff != 4'h0 |-> oe_ff == qsfi_pkg::OE_QUAD;
    endproperty
    a_quad_oe: assert property (p_quad_oe) else $error("quad mode drives partial bus");
    property p_spi_oe;
        !quad_ff && oe_ff != 4'h0 |-> oe_ff == qsfi_pkg::OE_SPI;
    endproperty
    a_spi_oe: assert property (p_spi_oe) else $error("single-bit mode drives wrong line");
    property p_sel;
        s_sel_start |-> $past(ce_fall);
    endproperty
    a_sel: assert property (p_sel) else $error("selected without chip-enable fall");
    property p_release;
        ce_s |=> oe_ff == 4'h0 && state_ff == qsfi_pkg::S_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("lines not released on deselect");
    property p_legacy;
        s_bad_legacy |=> state_ff == qsfi_pkg::S_DROP;
    endproperty
    a_legacy: assert property (p_legacy) else $error("non-legacy command taken");
    property p_wrap;
        kind_ff == qsfi_pkg::K_WRAP && state_ff == qsfi_pkg::S_OUT && $changed(ptr_ff)
            && $past(state_ff) == qsfi_pkg::S_OUT
            |-> (ptr_ff & ~wmask) == ($past(ptr_ff) & ~wmask);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap burst left its window");

endmodule
`default_nettype wire

// ==== qsfi_host.sv ====
// host controller model driving the flash link
`timescale 1ns/1ns
`default_nettype none
module qsfi_host (
    // clock
    input  wire logic       i_clk,
    // link pins
    input  wire logic [3:0] i_lines,
    output logic            o_ce_n,
    output logic            o_sck,
    output logic      [3:0] o_drv
);
    logic idle_hi;
    initial
    begin
        o_ce_n  = 1'b1;
        o_sck   = 1'b0;
        o_drv   = 4'h0;
        idle_hi = 1'b0;
    end
    // ====
    // timing, half period of 80 ns
    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask
    task automatic start(input logic m3);
        idle_hi = m3;
        o_sck   = m3;
        half();
        o_ce_n = 1'b0;
        half();
    endtask
    task automatic slot(input logic [3:0] d);
        o_sck = 1'b0;
        o_drv = d;
        half();
        o_sck = 1'b1;
        half();
    endtask
    task automatic put(input logic [7:0] b, input logic q);
        if (q)
        begin
            slot(b[7:4]);
            slot(b[3:0]);
        end
        else
            for (int i = 7; i >= 0; i--)
                slot({3'b000, b[i]});
    endtask
    // released lines toggle every slot
    task automatic get(input logic q, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < (q ? 2 : 8); i++)
        begin
            slot(~o_drv);
            b = q ? {b[3:0], i_lines} : {b[6:0], i_lines[1]};
        end
    endtask
    task automatic stop();
        o_sck = idle_hi;
        half();
        o_ce_n = 1'b1;
        o_drv  = ~o_drv;
        half();
        half();
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench of the quad serial flash front end
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) chk(nm, 32'(e), 32'(s));
module tb_top;
    logic                i_clk = 1'b0;
    logic                i_rst = 1'b1;
    logic [3:0]          hd, od, oe, lines;
    logic                ce_n, sck, secid, wv, quad;
    logic [23:0]         rd_addr, a;
    logic [7:0]          wd, last_wd, b, rdd, st;
    logic [1:0]          burst;
    qsfi_pkg::qsfi_evt_t evt, last_evt;
    logic [23:0]         tbl [7];
    int                  fail_count = 0;
    int                  n_compared = 0;
    int                  seed = 30;
    always #10 i_clk = ~i_clk;
    assign lines = (oe & od) | (~oe & hd);
    always @(posedge i_clk)
    begin
        if (evt.valid)
            last_evt <= evt;
        if (wv)
            last_wd <= wd;
    end
    qsfi_host HOST (.i_clk(i_clk), .i_lines(lines), .o_ce_n(ce_n), .o_sck(sck), .o_drv(hd));
    qsfi_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce_n(ce_n), .i_sck(sck),
        .i_quad_data_lines(lines), .o_quad_data_lines(od), .o_quad_data_lines_oe(oe),
        .o_rd_addr(rd_addr), .o_rd_secid(secid), .i_rd_data(rdd),
        .i_status(st), .o_evt(evt), .o_wdata(wd), .o_wvalid(wv), .o_quad(quad),
        .o_burst(burst));
    // ====
    // expectations and checks
    function automatic logic [7:0] mem(input logic [23:0] x);
        return x[7:0] ^ 8'hA5;
    endfunction
    // id space flips the top bit of each byte
    assign rdd = mem(rd_addr) ^ {secid, 7'h00};
    function automatic logic [6:0] exp_lock(input logic [23:0] x);
        if (x < 24'h00_8000)
            return {5'h00, x[14:13]};
        if (x < 24'h01_0000)
            return 7'h08;
        if (x >= 24'h1F_8000)
            return 7'h04 + {5'h00, x[14:13]};
        if (x >= 24'h1F_0000)
            return 7'h09;
        return 7'(x[23:16]) + 7'h09;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (e !== s)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic acmd(input logic [7:0] op, input logic [23:0] x, input logic q);
        HOST.put(op, q);
        for (int i = 2; i >= 0; i--)
            HOST.put(x[8*i +: 8], q);
    endtask
    initial
    begin
        #500_000;
        fail_count++;
        give_verdict();
    end
    // ====
    // tests
    initial
    begin
        tbl = '{24'h00_0000, 24'h00_6000, 24'h00_9000, 24'h01_0000, 24'h1F_2000,
                24'h1F_E000, 24'h12_3456};
        st = 8'h00;
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        a = 24'($random(seed));
        HOST.start(1'b0);
        acmd(8'h03, a, 1'b0);
        HOST.get(1'b0, b);
        `CHK("spi byte0", mem(a), b)
        `CHK("spi oe", 4'b0010, oe)
        HOST.get(1'b0, b);
        `CHK("spi byte1", mem(a + 24'h1), b)
        HOST.stop();
        `CHK("oe idle", 4'h0, oe)
        $display("test spi read done");
        HOST.start(1'b1);
        HOST.put(8'h9F, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            HOST.get(1'b0, b);
            `CHK("id", qsfi_pkg::ID_DEF[23 - 8*i -: 8], b)
        end
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'h05, 1'b0);
        HOST.get(1'b0, b);
        `CHK("refused oe", 4'h0, oe)
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'h03, 1'b0);
        HOST.put(8'h12, 1'b0);
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'h9F, 1'b0);
        HOST.get(1'b0, b);
        `CHK("after abort", qsfi_pkg::ID_DEF[23:16], b)
        HOST.stop();
        $display("test single-bit corners done");
        HOST.start(1'b0);
        HOST.put(8'h38, 1'b0);
        HOST.stop();
        `CHK("quad", 1'b1, quad)
        foreach (tbl[i])
        begin
            HOST.start(1'b0);
            acmd(8'h20, tbl[i], 1'b1);
            HOST.stop();
            `CHK("sector", tbl[i][23:12], last_evt.sector)
            `CHK("lock", exp_lock(tbl[i]), last_evt.lock_idx)
        end
        $display("test erase events done");
        a = 24'($random(seed));
        b = 8'($random(seed));
        HOST.start(1'b1);
        acmd(8'h02, a, 1'b1);
        HOST.put(b, 1'b1);
        HOST.stop();
        `CHK("evt addr", a, last_evt.addr)
        `CHK("wdata", b, last_wd)
        a = 24'($random(seed));
        HOST.start(1'b0);
        acmd(8'h03, a, 1'b1);
        HOST.get(1'b1, b);
        `CHK("quad byte", mem(a), b)
        `CHK("quad oe", 4'b1111, oe)
        HOST.stop();
        $display("test quad transfer done");
        HOST.start(1'b0);
        HOST.put(8'hC0, 1'b1);
        HOST.put(8'h02, 1'b1);
        HOST.stop();
        `CHK("burst", 2'b10, burst)
        a = 24'($random(seed)) | 24'h00_001F;
        HOST.start(1'b0);
        acmd(8'h0C, a, 1'b1);
        HOST.get(1'b1, b);
        `CHK("wrap last", mem(a), b)
        HOST.get(1'b1, b);
        `CHK("wrap first", mem(a & ~24'h00_001F), b)
        HOST.stop();
        $display("test wrap read done");
        a = {a[23:8], 8'($random(seed))};
        HOST.start(1'b0);
        HOST.put(8'h8C, 1'b1);
        HOST.put(a[7:0], 1'b1);
        HOST.get(1'b1, b);
        `CHK("page jump", mem(a), b)
        HOST.stop();
        a = a + 24'h1;
        a = {a[23:16], 16'($random(seed))};
        HOST.start(1'b0);
        HOST.put(8'h8D, 1'b1);
        HOST.put(a[15:8], 1'b1);
        HOST.put(a[7:0], 1'b1);
        HOST.get(1'b1, b);
        `CHK("block jump", mem(a), b)
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'h88, 1'b1);
        HOST.put(8'($random(seed)), 1'b1);
        HOST.put(8'($random(seed)) | 8'h1F, 1'b1);
        HOST.get(1'b1, b);
        `CHK("secid flag", 1'b1, secid)
        `CHK("secid last", mem(24'h00_001F) ^ 8'h80, b)
        HOST.get(1'b1, b);
        `CHK("secid wrap", mem(24'h00_0000) ^ 8'h80, b)
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'hB0, 1'b1);
        HOST.stop();
        `CHK("suspend", 8'hB0, last_evt.op)
        st = 8'($random(seed)) | 8'h80;
        HOST.start(1'b0);
        HOST.put(8'h05, 1'b1);
        HOST.get(1'b1, b);
        `CHK("status busy", st, b)
        st = st & 8'h7F;
        HOST.get(1'b1, b);
        `CHK("status ready", st, b)
        HOST.stop();
        $display("test jump, id space and status done");
        i_rst = 1'b1;
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        `CHK("reset quad", 1'b0, quad)
        `CHK("reset burst", 2'b00, burst)
        a = 24'($random(seed));
        HOST.start(1'b1);
        acmd(8'h0B, a, 1'b0);
        HOST.put(8'($random(seed)), 1'b0);
        HOST.get(1'b0, b);
        `CHK("fast read", mem(a), b)
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'h38, 1'b0);
        HOST.stop();
        HOST.start(1'b0);
        HOST.put(8'hFF, 1'b1);
        HOST.stop();
        `CHK("quad exit", 1'b0, quad)
        $display("test reset, fast read and exit done");
        give_verdict();
    end
endmodule
`default_nettype wire
